/* led_sink_blink_control.sv */
// Register file, time base and seven blinking, fading current sinks
// How it works
// - Law code 00: linear DAC, equal time per code during fades.
// - Law code 01: square DAC mapping, equal time per code.
// - Law codes 10 and 11: square DAC, two distinct nonlinear dwell profiles.
// - Enable register bits 0 to 6 drive sinks one to seven; bit 7 reserved.
// - Enable 1 turns a sink on; 0 turns it off regardless of timing.
// - Enabled sink with nonzero off-time stays on the shared on-time, then off.
// - On-time codes: 0.2, 0.6, 0.8, 1.2 seconds.
// - Off-times for sinks seven, six, five sit in bits 5:4, 3:2, 1:0.
// - Off-time codes: disabled, 0.6, 1.2, 1.8 seconds.
// - Nonzero off-time: off for off-time, on for on-time, repeating.
// - Enabled sink with off-time code 00 stays on without blinking.
// - Sinks four to one take off-times from the next register, same coding.
// - Fade-out and fade-in rates are nibbles 7:4 and 3:0; zero skips fading.
// - Cubic laws keep square DAC codes but vary dwell per code.
`timescale 1ns/1ns
`include "led_sink_params.svh"

module led_sink_blink_control #(
  parameter int unsigned BLINK_TICK_CYCLES =
    `BLINK_TICK_MS * 1000 * `CLK_MHZ,
  parameter int unsigned FADE_TICK_CYCLES = `FADE_TICK_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // Sink drive
  output logic [6:0]            sink_on,
  output logic [6:0][6:0]       sink_dac,
  output logic                  square_law
);
  import led_sink_pkg::*;

  localparam int BW = $clog2(BLINK_TICK_CYCLES + 1);
  localparam int FW = $clog2(FADE_TICK_CYCLES + 1);

  fade_transfer_law_t fade_transfer_law;
  logic [6:0]         sink_enable;
  logic [7:0]         sink_blink_time_upper;
  logic [7:0]         sink_blink_time_lower;
  logic [7:0]         fade_rates;
  logic [BW-1:0]      blink_div;
  logic [FW-1:0]      fade_div;
  logic               blink_tick;
  logic               fade_tick;
  logic [6:0][1:0]    off_sel;

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fade_transfer_law     <= LAW_LINEAR;
      sink_enable           <= 7'h00;
      sink_blink_time_upper <= `REG_RESET;
      sink_blink_time_lower <= `REG_RESET;
      fade_rates            <= `REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `REG_FADE_LAW:
          fade_transfer_law <= fade_transfer_law_t'(reg_wdata[1:0]);
        `REG_SINK_ENABLE:
          sink_enable <= reg_wdata[6:0];
        `REG_TIME_UPPER:
          sink_blink_time_upper <= reg_wdata;
        `REG_TIME_LOWER:
          sink_blink_time_lower <= reg_wdata;
        `REG_FADE_RATE:
          fade_rates <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Register reads; reserved and unmapped bits read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_FADE_LAW:    reg_rdata <= {6'h00, fade_transfer_law};
        `REG_SINK_ENABLE: reg_rdata <= {1'b0, sink_enable};
        `REG_TIME_UPPER:  reg_rdata <= sink_blink_time_upper;
        `REG_TIME_LOWER:  reg_rdata <= sink_blink_time_lower;
        `REG_FADE_RATE:   reg_rdata <= fade_rates;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Common time base
  always_ff @(posedge core_clk) begin
    if (srst || blink_div == BW'(BLINK_TICK_CYCLES - 1)) begin
      blink_div <= '0;
    end else begin
      blink_div <= blink_div + BW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || fade_div == FW'(FADE_TICK_CYCLES - 1)) begin
      fade_div <= '0;
    end else begin
      fade_div <= fade_div + FW'(1);
    end
  end

  assign blink_tick = (blink_div == BW'(BLINK_TICK_CYCLES - 1));
  assign fade_tick  = (fade_div == FW'(FADE_TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      square_law <= 1'b0;
    end else begin
      square_law <= (fade_transfer_law != LAW_LINEAR);
    end
  end

  // ==========================================================
  // Sinks
  genvar i;
  generate
    for (i = 0; i < `NUM_SINKS; i++) begin : g_sink
      if (i < 4) begin : g_lower
        assign off_sel[i] = sink_blink_time_lower[2*i +: 2];
      end else begin : g_upper
        assign off_sel[i] = sink_blink_time_upper[2*(i-4) +: 2];
      end

      sink_channel u_sink (
        .core_clk      (core_clk),
        .srst          (srst),
        .enable        (sink_enable[i]),
        .on_sel        (sink_blink_time_upper[`ON_TIME_LSB +: 2]),
        .off_sel       (off_sel[i]),
        .fade_law      (fade_transfer_law),
        .fade_in_rate  (fade_rates[`FADE_IN_LSB +: 4]),
        .fade_out_rate (fade_rates[`FADE_OUT_LSB +: 4]),
        .blink_tick    (blink_tick),
        .fade_tick     (fade_tick),
        .sink_on       (sink_on[i]),
        .dac_code      (sink_dac[i])
      );

      // ======================================================
      // Checks per sink
      a_disable_off: assert property (@(posedge core_clk) disable iff (srst)
        !sink_enable[i] |-> !sink_on[i] ##1 ($past(sink_enable[i]) ||
        sink_dac[i] == 7'h00))
        else $error("disabled sink not off");

      a_enable_start: assert property (@(posedge core_clk) disable iff (srst)
        $rose(sink_enable[i]) |-> sink_on[i])
        else $error("sink did not start in on phase");

      a_steady_on: assert property (@(posedge core_clk) disable iff (srst)
        sink_enable[i] && $past(sink_enable[i]) && $past(off_sel[i] == 2'b00)
        |-> sink_on[i])
        else $error("sink not steady on with off-time disabled");

      a_off_at_tick: assert property (@(posedge core_clk) disable iff (srst)
        $fell(sink_on[i]) && sink_enable[i] |-> $past(blink_tick))
        else $error("sink turned off between ticks");

      a_on_at_tick: assert property (@(posedge core_clk) disable iff (srst)
        $rose(sink_on[i]) |-> $rose(sink_enable[i]) || $past(blink_tick)
        || $past(off_sel[i] == 2'b00))
        else $error("sink turned on without cause");

      a_rate_jump: assert property (@(posedge core_clk) disable iff (srst)
        sink_on[i] && fade_rates[3:0] == 4'h0 && sink_enable[i]
        |=> sink_enable[i] |-> sink_dac[i] == 7'h7f)
        else $error("zero fade-in rate did not jump to full");

      a_fade_step: assert property (@(posedge core_clk) disable iff (srst)
        $past(sink_enable[i]) && $past(fade_rates[3:0] != 4'h0)
        && $past(fade_rates[7:4] != 4'h0) |->
        (sink_dac[i] - $past(sink_dac[i]) <= 7'h01 ||
         $past(sink_dac[i]) - sink_dac[i] <= 7'h01))
        else $error("fade moved more than one code");

      c_blink: cover property (@(posedge core_clk) disable iff (srst)
        sink_enable[i] && $fell(sink_on[i]));
    end
  endgenerate

  a_enable_map: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == 8'h10 |=> sink_enable == $past(reg_wdata[6:0]))
    else $error("enable bits not mapped to sinks");

  a_off_fields: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == 8'h11 |=> off_sel[6] == $past(reg_wdata[5:4])
    && off_sel[4] == $past(reg_wdata[1:0]))
    else $error("off-time fields misplaced");

  a_law_select: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && reg_addr == 8'h0f |=> ##1
    square_law == ($past(reg_wdata[1:0], 2) != 2'b00))
    else $error("law selection not applied");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == 8'h10 |=> reg_rdata[7] == 1'b0)
    else $error("reserved enable bit read nonzero");

  c_cubic: cover property (@(posedge core_clk) disable iff (srst)
    fade_transfer_law == LAW_CUBIC_11 && sink_dac[0] != 7'h00);
  c_fade_full: cover property (@(posedge core_clk) disable iff (srst)
    sink_dac[6] == 7'h7f);
  c_read: cover property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == 8'h13);

endmodule : led_sink_blink_control

/* led_sink_params.svh */
// Offsets, field positions, reset values and timing counts of the sink block
`ifndef LED_SINK_PARAMS_SVH
`define LED_SINK_PARAMS_SVH

// ==========================================================
// Clock and time base
`define CLK_MHZ          10
`define BLINK_TICK_MS    200
`define FADE_TICK_US     787

// ==========================================================
// Register offsets
`define REG_FADE_LAW     8'h0f
`define REG_SINK_ENABLE  8'h10
`define REG_TIME_UPPER   8'h11
`define REG_TIME_LOWER   8'h12
`define REG_FADE_RATE    8'h13

// ==========================================================
// Fields and reset values
`define NUM_SINKS        7
`define SINK_EN_BITS     7
`define LAW_BITS         2
`define ON_TIME_LSB      6
`define FADE_OUT_LSB     4
`define FADE_IN_LSB      0
`define REG_RESET        8'h00
`define DAC_FULL         7'h7f
`define DAC_ZERO         7'h00

// ==========================================================
// Blink lengths in time base ticks
`define ON_TICKS_0       4'h1
`define ON_TICKS_1       4'h3
`define ON_TICKS_2       4'h4
`define ON_TICKS_3       4'h6
`define OFF_TICKS_1      4'h3
`define OFF_TICKS_2      4'h6
`define OFF_TICKS_3      4'h9

`endif

/* led_sink_pkg.sv */
// Types and field decoders shared by the sink control block
`include "led_sink_params.svh"

package led_sink_pkg;

  typedef enum logic [1:0] {
    LAW_LINEAR   = 2'b00,
    LAW_SQUARE   = 2'b01,
    LAW_CUBIC_10 = 2'b10,
    LAW_CUBIC_11 = 2'b11
  } fade_transfer_law_t;

  typedef enum logic {
    PH_OFF = 1'b0,
    PH_ON  = 1'b1
  } blink_phase_t;

  // On length in time base ticks
  function automatic logic [3:0] on_ticks(input logic [1:0] sel);
    unique case (sel)
      2'b00: on_ticks = `ON_TICKS_0;
      2'b01: on_ticks = `ON_TICKS_1;
      2'b10: on_ticks = `ON_TICKS_2;
      2'b11: on_ticks = `ON_TICKS_3;
    endcase
  endfunction : on_ticks

  // Off length in time base ticks; code zero means no blinking
  function automatic logic [3:0] off_ticks(input logic [1:0] sel);
    unique case (sel)
      2'b00: off_ticks = 4'h0;
      2'b01: off_ticks = `OFF_TICKS_1;
      2'b10: off_ticks = `OFF_TICKS_2;
      2'b11: off_ticks = `OFF_TICKS_3;
    endcase
  endfunction : off_ticks

  // Full scale fade time in tenths of a second
  function automatic logic [5:0] rate_units(input logic [3:0] r);
    unique case (r)
      4'h0: rate_units = 6'h00;
      4'h1: rate_units = 6'h03;
      4'h2: rate_units = 6'h06;
      4'h3: rate_units = 6'h09;
      4'h4: rate_units = 6'h0c;
      4'h5: rate_units = 6'h0f;
      4'h6: rate_units = 6'h12;
      4'h7: rate_units = 6'h15;
      4'h8: rate_units = 6'h18;
      4'h9: rate_units = 6'h1b;
      4'ha: rate_units = 6'h1e;
      4'hb: rate_units = 6'h23;
      4'hc: rate_units = 6'h28;
      4'hd: rate_units = 6'h2d;
      4'he: rate_units = 6'h32;
      4'hf: rate_units = 6'h37;
    endcase
  endfunction : rate_units

endpackage : led_sink_pkg

/* sink_channel.sv */
// One current sink: blink phase and fade of its DAC code
`timescale 1ns/1ns
`include "led_sink_params.svh"

module sink_channel (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            srst,
  // Settings
  input  wire logic                            enable,
  input  wire logic [1:0]                      on_sel,
  input  wire logic [1:0]                      off_sel,
  input  wire led_sink_pkg::fade_transfer_law_t fade_law,
  input  wire logic [3:0]                      fade_in_rate,
  input  wire logic [3:0]                      fade_out_rate,
  // Time base
  input  wire logic                            blink_tick,
  input  wire logic                            fade_tick,
  // Sink drive
  output logic                                 sink_on,
  output logic [6:0]                           dac_code
);
  import led_sink_pkg::*;

  blink_phase_t phase;
  logic [3:0]   blink_cnt;
  logic [7:0]   dwell_cnt;
  logic [7:0]   dwell_len;
  logic [6:0]   target;
  logic [3:0]   rate;
  logic [2:0]   weight;

  // ==========================================================
  // Blink phase
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      phase     <= PH_ON;
      blink_cnt <= 4'h0;
    end else if (off_sel == 2'b00) begin
      phase     <= PH_ON;
      blink_cnt <= 4'h0;
    end else if (blink_tick) begin
      unique case (phase)
        PH_ON: begin
          if (blink_cnt + 4'h1 >= on_ticks(on_sel)) begin
            phase     <= PH_OFF;
            blink_cnt <= 4'h0;
          end else begin
            blink_cnt <= blink_cnt + 4'h1;
          end
        end
        PH_OFF: begin
          if (blink_cnt + 4'h1 >= off_ticks(off_sel)) begin
            phase     <= PH_ON;
            blink_cnt <= 4'h0;
          end else begin
            blink_cnt <= blink_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  assign sink_on = enable && (phase == PH_ON);

  // ==========================================================
  // Fade toward the target code
  always_comb begin
    target = sink_on ? `DAC_FULL : `DAC_ZERO;
    rate   = (target > dac_code) ? fade_in_rate : fade_out_rate;
    unique case (fade_law)
      LAW_CUBIC_10: weight = 3'h1 + {1'b0, dac_code[6:5]};
      LAW_CUBIC_11: weight = 3'h4 - {1'b0, dac_code[6:5]};
      default:      weight = 3'h1;
    endcase
    // Widened first so that the longest dwell, 55 times 4, does not wrap
    dwell_len = {2'b00, rate_units(rate)} * {5'h00, weight};
  end

  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      dac_code  <= `DAC_ZERO;
      dwell_cnt <= 8'h00;
    end else if (dac_code == target) begin
      dwell_cnt <= 8'h00;
    end else if (rate == 4'h0) begin
      dac_code  <= target;
      dwell_cnt <= 8'h00;
    end else if (fade_tick) begin
      if (dwell_cnt + 8'h01 >= dwell_len) begin
        dac_code  <= (target > dac_code) ? dac_code + 7'h01
                                         : dac_code - 7'h01;
        dwell_cnt <= 8'h00;
      end else begin
        dwell_cnt <= dwell_cnt + 8'h01;
      end
    end
  end

endmodule : sink_channel

/* host_model.sv */
// Host software model driving the block's parallel register port
`timescale 1ns/1ns

module host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe, launched just after an edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~data;
  endtask : write_reg

  // One-cycle read strobe; data is registered at the taking edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd   = 1'b0;
    data     = reg_rdata;
  endtask : read_reg
endmodule : host_model

/* led_sink_blink_control_tb_top.sv */
// Self-checking bench for the sink blink and fade control block
`timescale 1ns/1ns
`include "led_sink_params.svh"

module led_sink_blink_control_tb_top;
  localparam int TICK = 20;
  localparam int FTICK = 2;
  logic             core_clk;
  logic             srst;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic [6:0]       sink_on;
  logic [6:0][6:0]  sink_dac;
  logic             square_law;
  int               errors;
  int               check_count;
  int               cycles;

  // ==========================================================
  // Design and host model
  led_sink_blink_control #(
    .BLINK_TICK_CYCLES (TICK),
    .FADE_TICK_CYCLES  (FTICK)
  ) dut_u (
    .core_clk   (core_clk),
    .srst       (srst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .sink_on    (sink_on),
    .sink_dac   (sink_dac),
    .square_law (square_law)
  );

  host_model host_u (
    .core_clk  (core_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // ==========================================================
  // Clock, timeout and helpers
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_reg(addr, d);
    check("reg_rdata", {8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  // Lengths of one full off phase and the on phase after it
  task automatic blink_len(input int idx, output int lo, output int hi);
    int n;
    n  = 0;
    lo = 0;
    hi = 0;
    while (sink_on[idx] !== 1'b0 && n < 400) begin step(); n++; end
    while (sink_on[idx] === 1'b0 && lo < 400) begin step(); lo++; end
    while (sink_on[idx] === 1'b1 && hi < 400) begin step(); hi++; end
  endtask : blink_len

  // ==========================================================
  // Main sequence
  int          on_t[4]  = '{1, 3, 4, 6};
  int          off_t[4] = '{0, 3, 6, 9};
  int          dwell_t[4] = '{6, 6, 6, 24};
  logic [7:0]  ra[6] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
  logic [7:0]  rw[6] = '{8'hff, 8'hff, 8'ha5, 8'h5a, 8'hc3, 8'hff};
  logic [7:0]  rx[6] = '{8'h03, 8'h7f, 8'ha5, 8'h5a, 8'hc3, 8'h00};

  initial begin
    int lo, hi, oc, fc, n;
    srst = 1'b1;
    errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge core_clk);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(ra[i], 8'h00);
    for (int i = 0; i < 6; i++) begin
      host_u.write_reg(ra[i], rw[i]);
      rd_chk(ra[i], rx[i]);
    end
    // All sinks enabled with every off-time disabled stay lit
    host_u.write_reg(`REG_TIME_UPPER, 8'h00);
    host_u.write_reg(`REG_TIME_LOWER, 8'h00);
    host_u.write_reg(`REG_FADE_RATE, 8'h00);
    repeat (8 * TICK) step();
    check("sink_on", {9'h000, sink_on}, 16'h007f);
    // One sink at a time: own enable bit, own off field, shared on field
    for (int k = 0; k < 7; k++) begin
      oc = k % 4;
      fc = k % 3 + 1;
      host_u.write_reg(`REG_SINK_ENABLE, 8'h00);
      step();
      check("sink_dac", {9'h000, sink_dac[k]}, 16'h0000);
      host_u.write_reg(`REG_TIME_LOWER, (k < 4) ? 8'(fc << (2 * k)) : 8'h00);
      host_u.write_reg(`REG_TIME_UPPER,
                       8'(oc << 6) | ((k >= 4) ? 8'(fc << (2 * k - 8)) : 8'h00));
      host_u.write_reg(`REG_SINK_ENABLE, 8'(1 << k));
      check("sink_on", {9'h000, sink_on}, 16'(1 << k));
      step();
      check("sink_dac", {9'h000, sink_dac[k]}, 16'h007f);
      blink_len(k, lo, hi);
      check("off_len", 16'(lo), 16'(off_t[fc] * TICK));
      check("on_len", 16'(hi), 16'(on_t[oc] * TICK));
      blink_len(k, lo, hi);
      check("off_len", 16'(lo), 16'(off_t[fc] * TICK));
      check("on_len", 16'(hi), 16'(on_t[oc] * TICK));
    end
    host_u.write_reg(`REG_SINK_ENABLE, 8'h00);
    check("sink_on", {9'h000, sink_on}, 16'h0000);
    // Fade-in dwell per code for each transfer law
    host_u.write_reg(`REG_TIME_UPPER, 8'h00);
    host_u.write_reg(`REG_TIME_LOWER, 8'h00);
    host_u.write_reg(`REG_FADE_RATE, 8'h01);
    for (int l = 0; l < 4; l++) begin
      host_u.write_reg(`REG_FADE_LAW, 8'(l));
      step();
      check("square_law", {15'h0000, square_law}, 16'(l != 0));
      host_u.write_reg(`REG_SINK_ENABLE, 8'h01);
      n = 0;
      while (sink_dac[0] !== 7'h02 && n < 200) begin step(); n++; end
      n = 0;
      while (sink_dac[0] === 7'h02 && n < 200) begin step(); n++; end
      check("dwell", 16'(n), 16'(dwell_t[l]));
      host_u.write_reg(`REG_SINK_ENABLE, 8'h00);
    end
    // A second reset in mid-run clears the registers
    host_u.write_reg(`REG_SINK_ENABLE, 8'h7f);
    srst = 1'b1;
    step();
    srst = 1'b0;
    check("sink_on", {9'h000, sink_on}, 16'h0000);
    rd_chk(`REG_SINK_ENABLE, 8'h00);
    tally_and_finish();
  end
endmodule : led_sink_blink_control_tb_top
